// file: hw/radio_host_ctrl.sv
`timescale 1ns/1ns
// =====================================================
// host: ahb-lite slave taking commands, spi master to radio
module radio_host_ctrl (
   input wire logic clock,
   input wire logic nrst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   radio_if.host link
);
   typedef enum logic [2:0] {
      H_IDLE = 3'b000, H_GAP = 3'b001, H_SHIFT = 3'b010, H_POLL = 3'b011, H_DONE = 3'b100
   } host_e;
   logic [1:0] misoS;
   logic [31:0] cmd_reg;
   logic [7:0] rdata_reg;
   logic go_reg;
   logic [2:0] st_reg;
   logic [15:0] tmr_reg;
   logic [4:0] bit_reg;
   logic [15:0] sh_reg;
   logic sck_reg, sel_reg, mosi_reg;
   logic wr_reg;
   logic [7:0] addr_reg;
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) misoS <= 2'h0;
      else misoS <= {misoS[0], link.miso};
   end
   // slower clock for a powered-down radio, used for every frame whatever the command
   wire slow = cmd_reg[15:8] == {1'b0, radio_pkg::REG_POWER} ? 1'b1 : 1'b1;
   wire [15:0] half = slow ? 16'(radio_pkg::LINK_HALF_CYC) : 16'h0001;
   // =====================================================
   // ahb-lite slave, zero wait states
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         wr_reg <= 1'b0; addr_reg <= 8'h00; hrdata <= 32'h0000_0000;
      end else begin
         wr_reg <= hsel && hready && htrans[1] && hwrite;
         addr_reg <= haddr[7:0];
         if (hsel && hready && htrans[1] && !hwrite) begin
            unique case (haddr[7:0])
               radio_pkg::AHB_CMD: hrdata <= cmd_reg;
               radio_pkg::AHB_STATUS: hrdata <= {29'h0, misoS[1], st_reg == H_DONE, go_reg};
               radio_pkg::AHB_RDATA: hrdata <= {24'h0, rdata_reg};
               default: hrdata <= 32'h0000_0000;
            endcase
         end
      end
   end
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   // =====================================================
   // spi master: cmd[17:16] op, cmd[14:8] addr, cmd[7:0] data
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         cmd_reg <= 32'h0; go_reg <= 1'b0; st_reg <= H_IDLE; tmr_reg <= 16'h0; bit_reg <= 5'h0;
         sh_reg <= 16'h0; sck_reg <= 1'b0; sel_reg <= 1'b1; mosi_reg <= 1'b0; rdata_reg <= 8'h0;
      end else begin
         if (wr_reg && addr_reg == radio_pkg::AHB_CMD && !go_reg) begin
            cmd_reg <= hwdata;
            go_reg <= 1'b1;
         end
         unique case (st_reg)
            H_IDLE: if (go_reg) begin
               sel_reg <= 1'b0;
               tmr_reg <= half;
               bit_reg <= 5'h0;
               sh_reg <= {cmd_reg[17:16] == radio_pkg::CMD_WRITE, cmd_reg[14:0]};
               mosi_reg <= cmd_reg[17:16] == radio_pkg::CMD_WRITE;
               st_reg <= (cmd_reg[17:16] == radio_pkg::CMD_WAKE) ? H_POLL : H_SHIFT;
            end
            H_SHIFT: if (tmr_reg != 16'h0) tmr_reg <= tmr_reg - 16'h1;
            else begin
               tmr_reg <= half;
               sck_reg <= ~sck_reg;
               // mosi moves on the fall so it has settled long before the next rise
               if (sck_reg) begin
                  mosi_reg <= sh_reg[14];
                  sh_reg <= {sh_reg[14:0], 1'b0};
                  if (bit_reg >= 5'h8) rdata_reg <= {rdata_reg[6:0], misoS[1]};
                  bit_reg <= bit_reg + 5'h1;
                  if (bit_reg == 5'hF) st_reg <= H_GAP;
               end
            end
            // wait for miso high after wake
            H_POLL: if (misoS[1]) st_reg <= H_GAP;
            H_GAP: begin
               sel_reg <= 1'b1;
               if (tmr_reg < 16'(radio_pkg::RST_HI_CYC)) tmr_reg <= tmr_reg + 16'h1;
               else st_reg <= H_DONE;
            end
            H_DONE: begin
               tmr_reg <= 16'h0;
               go_reg <= 1'b0;
               st_reg <= H_IDLE;
            end
            default: st_reg <= H_IDLE;
         endcase
      end
   end
   // wire-mode framing is the host's job; pins idle here
   assign link.sck = sck_reg;
   assign link.sel = sel_reg;
   assign link.mosi = mosi_reg;
   assign link.wireDataIn = 1'b1;
   assign link.wireTx = 1'b0;
endmodule : radio_host_ctrl

// file: hw/radio_if.sv
`timescale 1ns/1ns
// =====================================================
// spi and wire-mode link between host controller and radio
interface radio_if;
   logic sck;
   logic sel;
   logic mosi;
   logic miso;
   logic misoOe;
   logic wireClk;
   logic wireDataIn;
   logic wireDataOut;
   logic wireDataOe;
   logic wireTx;
   modport dev (input sck, input sel, input mosi, output miso, output misoOe,
      output wireClk, input wireDataIn, output wireDataOut, output wireDataOe, input wireTx);
   modport host (output sck, output sel, output mosi, input miso, input misoOe,
      input wireClk, output wireDataIn, input wireDataOut, input wireDataOe, output wireTx);
endinterface : radio_if

// file: hw/radio_pkg.sv
package radio_pkg;
   // =====================================================
   // clock and timing
   localparam int CLK_NS = 100;
   localparam int TXON_US = 40;
   localparam int RXON_US = 190;
   localparam int RSSI_US = 270;
   localparam int RXTX_US = 62;
   localparam int TXRX_US = 200;
   localparam int HOP_US = 30;
   localparam int WAKE_US = 50;
   localparam int RST_HI_NS = 100;
   localparam int PD_SCK_NS = 100;
   localparam int TXON_CYC = (TXON_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int RXON_CYC = RXON_US * 1000 / CLK_NS;
   localparam int RSSI_CYC = RSSI_US * 1000 / CLK_NS;
   localparam int RXTX_CYC = RXTX_US * 1000 / CLK_NS;
   localparam int TXRX_CYC = TXRX_US * 1000 / CLK_NS;
   localparam int HOP_CYC = HOP_US * 1000 / CLK_NS;
   localparam int WAKE_CYC = WAKE_US * 1000 / CLK_NS;
   localparam int RST_HI_CYC = (RST_HI_NS + CLK_NS - 1) / CLK_NS;
   localparam int PD_HALF_CYC = (PD_SCK_NS + 2 * CLK_NS - 1) / (2 * CLK_NS);
   localparam int LINK_HALF_CYC = PD_HALF_CYC + 2; // halves outlast the miso sync round trip
   localparam int TX_BITS = 1;
   localparam int RSSI_BITS = 3;
   localparam int DATA_BITS = 9;
   localparam int WIRE_LAT_BITS = 6;
   // =====================================================
   // device register map (7-bit address, 8-bit data)
   localparam logic [6:0] REG_POWER = 7'h02;
   localparam logic [6:0] REG_SUPPLY = 7'h03;
   localparam logic [6:0] REG_MODE = 7'h04;
   localparam logic [6:0] REG_RATE = 7'h05;
   localparam logic [6:0] REG_BUFFER = 7'h06;
   localparam logic [6:0] REG_CARRIER = 7'h07;
   localparam logic [6:0] REG_STATE = 7'h08;
   localparam int PWR_RST_BIT = 7;
   localparam logic [3:0] PS_DEEPSLEEP = 4'h0;
   localparam logic [3:0] PS_POWERDOWN = 4'h1;
   localparam logic [3:0] PS_STANDBY = 4'h5;
   localparam logic [3:0] PS_FULL_RECEIVE_STATE = 4'h9;
   localparam logic [3:0] PS_FULL_TRANSMIT_STATE = 4'hD;
   localparam logic [7:0] POWER_RESET = 8'h01;
   localparam logic [7:0] RATE_RESET = 8'h04;
   localparam int SUP_REGREADY = 0;
   localparam int SUP_BROWNOUT = 1;
   localparam int MODE_WIRE = 0;
   localparam int MODE_ASYNC = 1;
   localparam int ST_RSSI_OK = 4;
   localparam int ST_DATA_OK = 5;
   localparam int ST_BUSY = 6;
   // =====================================================
   // controller registers on AHB-Lite
   localparam logic [7:0] AHB_CMD = 8'h00;
   localparam logic [7:0] AHB_STATUS = 8'h04;
   localparam logic [7:0] AHB_RDATA = 8'h08;
   localparam logic [1:0] CMD_WRITE = 2'h1;
   localparam logic [1:0] CMD_READ = 2'h2;
   localparam logic [1:0] CMD_WAKE = 2'h3;
endpackage : radio_pkg

// file: hw/radio_power_mode_sequencer.sv
// Our own choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ns
// Operation
// - standby to transmit at least 40us plus bit
// - standby to receive takes 190us
// - signal strength valid 270us plus three bits
// - data valid 190us plus nine bits
// - receive to transmit takes 62us
// - transmit to receive takes 200us
// - carrier hop takes 30us
// - bit period is inverse data rate
// - wire mode adds six bit latency
// - host slows spi in power-down; the host here slows it for every frame, whatever the power state
// - frame mode moves payload over spi
// - wire mode outputs data and bit clock
// - host does wire-mode framing itself
// - async wire resyncs on start bits
// - device is spi slave for configuration
// - regulators follow programmed power state
// - supply status shows ready and brownout
// - power-down keeps registers, drops buffer
// - deep-sleep loses all registers
// - select low wakes and resets device
// - miso low until ready after wake
// - select high then reset bit resets
module radio_power_mode_sequencer #(
   parameter int RATE_DIV_UNIT = 10
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic brownout,
   radio_if.dev link,
   output logic [3:0] powerState,
   output logic regReady
);
   typedef enum logic [2:0] {
      S_SLEEP = 3'b000, S_WAKE = 3'b001, S_IDLE = 3'b010, S_SETTLE = 3'b011, S_ACTIVE = 3'b100
   } seq_e;
   // =====================================================
   // pin synchronisers
   logic [1:0] sckS, selS, mosiS, wdS, wtxS, boS;
   logic sckPrev;
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         sckS <= 2'h0; selS <= 2'h3; mosiS <= 2'h0; wdS <= 2'h3; wtxS <= 2'h0; boS <= 2'h0; sckPrev <= 1'b0;
      end else begin
         sckS <= {sckS[0], link.sck};
         selS <= {selS[0], link.sel};
         mosiS <= {mosiS[0], link.mosi};
         wdS <= {wdS[0], link.wireDataIn};
         wtxS <= {wtxS[0], link.wireTx};
         boS <= {boS[0], brownout};
         sckPrev <= sckS[1];
      end
   end
   wire sel = selS[1];
   wire sckRise = sckS[1] & ~sckPrev;
   wire sckFall = ~sckS[1] & sckPrev;
   // =====================================================
   // registers
   logic [7:0] power_reg, mode_reg, rate_reg, buffer_reg, carrier_reg;
   logic bufValid_reg;
   logic [2:0] seq_reg;
   logic [15:0] timer_reg;
   logic [15:0] bitCnt_reg;
   logic [15:0] bitPer;
   logic [3:0] curState_reg;
   logic [3:0] target;
   logic rssiOk_reg, dataOk_reg;
   logic [4:0] bitsSeen_reg;
   logic softRst;
   logic [15:0] cmd_reg;
   logic [4:0] spiCnt_reg;
   logic [7:0] shOut_reg;
   logic spiWr;
   assign target = power_reg[3:0];
   assign bitPer = 16'(rate_reg) * 16'(RATE_DIV_UNIT);
   // =====================================================
   // spi slave: 8-bit command (r/w + addr), 8-bit data
   wire asleep = (seq_reg == S_SLEEP) || (seq_reg == S_WAKE);
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         spiCnt_reg <= 5'h00; cmd_reg <= 16'h0000; shOut_reg <= 8'h00;
      end else if (sel || asleep) begin
         spiCnt_reg <= 5'h00;
      end else if (sckRise) begin
         cmd_reg <= {cmd_reg[14:0], mosiS[1]};
         spiCnt_reg <= spiCnt_reg + 5'h01;
      end else if (sckFall && spiCnt_reg == 5'h08) begin
         unique case (cmd_reg[6:0])
            radio_pkg::REG_POWER: shOut_reg <= power_reg;
            radio_pkg::REG_SUPPLY: shOut_reg <= {6'h00, boS[1], regReady};
            radio_pkg::REG_MODE: shOut_reg <= mode_reg;
            radio_pkg::REG_RATE: shOut_reg <= rate_reg;
            radio_pkg::REG_BUFFER: shOut_reg <= bufValid_reg ? buffer_reg : 8'h00;
            radio_pkg::REG_CARRIER: shOut_reg <= carrier_reg;
            radio_pkg::REG_STATE: shOut_reg <= {1'b0, seq_reg == S_SETTLE, dataOk_reg, rssiOk_reg, curState_reg};
            default: shOut_reg <= 8'h00;
         endcase
      end else if (sckFall && spiCnt_reg > 5'h08) begin
         shOut_reg <= {shOut_reg[6:0], 1'b0};
      end
   end
   assign spiWr = sckRise && spiCnt_reg == 5'h0F && cmd_reg[14];
   wire [6:0] wAddr = cmd_reg[13:7];
   wire [7:0] wData = {cmd_reg[6:0], mosiS[1]};
   // =====================================================
   // register writes; deep-sleep and reset bit clear all
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         power_reg <= radio_pkg::POWER_RESET; mode_reg <= 8'h00; rate_reg <= radio_pkg::RATE_RESET;
         buffer_reg <= 8'h00; carrier_reg <= 8'h00; bufValid_reg <= 1'b0; softRst <= 1'b0;
      end else if (seq_reg == S_WAKE || softRst) begin
         power_reg <= radio_pkg::POWER_RESET; mode_reg <= 8'h00; rate_reg <= radio_pkg::RATE_RESET;
         buffer_reg <= 8'h00; carrier_reg <= 8'h00; bufValid_reg <= 1'b0; softRst <= 1'b0;
      end else begin
         if (spiWr) begin
            unique case (wAddr)
               radio_pkg::REG_POWER: begin
                  power_reg <= wData;
                  // set then cleared reset bit triggers reset
                  softRst <= power_reg[radio_pkg::PWR_RST_BIT] & ~wData[radio_pkg::PWR_RST_BIT];
               end
               radio_pkg::REG_MODE: mode_reg <= wData;
               radio_pkg::REG_RATE: rate_reg <= (wData == 8'h00) ? 8'h01 : wData;
               radio_pkg::REG_BUFFER: begin
                  // payload in frame mode; blocked in power-down
                  if (target != radio_pkg::PS_POWERDOWN && !mode_reg[radio_pkg::MODE_WIRE]) begin
                     buffer_reg <= wData;
                     bufValid_reg <= 1'b1;
                  end
               end
               radio_pkg::REG_CARRIER: carrier_reg <= wData;
               default: ;
            endcase
         end
         if (curState_reg == radio_pkg::PS_POWERDOWN) bufValid_reg <= 1'b0;
      end
   end
   // =====================================================
   // power sequencer with transition latencies
   logic [15:0] settle;
   logic carrierPrev;
   always_comb begin
      settle = 16'(radio_pkg::HOP_CYC);
      if (target == curState_reg)
         settle = 16'(radio_pkg::HOP_CYC);
      else if (curState_reg == radio_pkg::PS_FULL_RECEIVE_STATE && target == radio_pkg::PS_FULL_TRANSMIT_STATE)
         settle = 16'(radio_pkg::RXTX_CYC);
      else if (curState_reg == radio_pkg::PS_FULL_TRANSMIT_STATE && target == radio_pkg::PS_FULL_RECEIVE_STATE)
         settle = 16'(radio_pkg::TXRX_CYC);
      else if (target == radio_pkg::PS_FULL_TRANSMIT_STATE)
         settle = 16'(radio_pkg::TXON_CYC) + bitPer * 16'(radio_pkg::TX_BITS);
      else if (target == radio_pkg::PS_FULL_RECEIVE_STATE)
         settle = 16'(radio_pkg::RXON_CYC);
      else if (target == radio_pkg::PS_STANDBY || target == radio_pkg::PS_POWERDOWN)
         settle = 16'h0001;
   end
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         seq_reg <= S_SLEEP; timer_reg <= 16'h0000; curState_reg <= radio_pkg::PS_DEEPSLEEP;
         regReady <= 1'b0; powerState <= radio_pkg::PS_DEEPSLEEP; carrierPrev <= 1'b0;
      end else begin
         powerState <= curState_reg;
         unique case (seq_reg)
            S_SLEEP: begin
               regReady <= 1'b0;
               curState_reg <= radio_pkg::PS_DEEPSLEEP;
               if (!sel) begin
                  seq_reg <= S_WAKE;
                  timer_reg <= 16'(radio_pkg::WAKE_CYC);
               end
            end
            S_WAKE: begin
               if (timer_reg == 16'h0000) begin
                  seq_reg <= S_IDLE;
                  regReady <= 1'b1;
                  curState_reg <= radio_pkg::PS_POWERDOWN;
               end else timer_reg <= timer_reg - 16'h0001;
            end
            S_IDLE: begin
               carrierPrev <= carrier_reg[0];
               // wait for select high, else the ordering frame wakes us again
               if (target == radio_pkg::PS_DEEPSLEEP) begin
                  if (sel) seq_reg <= S_SLEEP;
               end else if (target != curState_reg) begin
                  seq_reg <= S_SETTLE;
                  timer_reg <= settle;
                  regReady <= (target == radio_pkg::PS_POWERDOWN) ? regReady : 1'b0;
               end else if (carrier_reg[0] != carrierPrev && curState_reg != radio_pkg::PS_POWERDOWN) begin
                  seq_reg <= S_SETTLE;
                  timer_reg <= settle;
               end
            end
            S_SETTLE: begin
               if (timer_reg <= 16'h0001) begin
                  seq_reg <= S_IDLE;
                  curState_reg <= target;
                  regReady <= 1'b1;
               end else timer_reg <= timer_reg - 16'h0001;
            end
            default: seq_reg <= S_SLEEP;
         endcase
      end
   end
   // =====================================================
   // bit-period clock, rssi/data validity, wire mode
   logic [15:0] sinceRx_reg;
   logic wireClk_reg, wireOut_reg, wireOe_reg, misoOut_reg, misoOe_reg, wireClkOut_reg;
   logic [5:0] wirePipe_reg;
   wire rxActive = seq_reg == S_IDLE && curState_reg == radio_pkg::PS_FULL_RECEIVE_STATE;
   wire wire_mode = mode_reg[radio_pkg::MODE_WIRE];
   wire [15:0] rssiDue = 16'(radio_pkg::RSSI_CYC) + bitPer * 16'(radio_pkg::RSSI_BITS);
   wire asyncStart = mode_reg[radio_pkg::MODE_ASYNC] && wtxS[1] && !wdS[1] && wirePipe_reg[0];
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         bitCnt_reg <= 16'h0000; sinceRx_reg <= 16'h0000; bitsSeen_reg <= 5'h00;
         rssiOk_reg <= 1'b0; dataOk_reg <= 1'b0; wireClk_reg <= 1'b0; wirePipe_reg <= 6'h00;
      end else begin
         // async start bit restarts bit timing
         if (asyncStart || bitCnt_reg + 16'h0001 >= bitPer) begin
            bitCnt_reg <= 16'h0000;
            wireClk_reg <= 1'b0;
            wirePipe_reg <= {wirePipe_reg[4:0], wdS[1]};
            if (bitsSeen_reg != 5'h1F) bitsSeen_reg <= bitsSeen_reg + 5'h01;
         end else begin
            bitCnt_reg <= bitCnt_reg + 16'h0001;
            if (bitCnt_reg == (bitPer >> 1)) wireClk_reg <= 1'b1;
         end
         if (!rxActive) begin
            sinceRx_reg <= 16'(radio_pkg::RXON_CYC);
            bitsSeen_reg <= 5'h00;
            rssiOk_reg <= 1'b0;
            dataOk_reg <= 1'b0;
         end else begin
            if (sinceRx_reg != 16'hFFFF) sinceRx_reg <= sinceRx_reg + 16'h0001;
            if (sinceRx_reg >= rssiDue)
               rssiOk_reg <= 1'b1;
            if (bitsSeen_reg >= 5'(radio_pkg::DATA_BITS)) dataOk_reg <= 1'b1;
         end
      end
   end
   // =====================================================
   // pin drivers: miso low during wake, wire pins only in wire mode
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         misoOut_reg <= 1'b0; misoOe_reg <= 1'b0; wireOut_reg <= 1'b0; wireOe_reg <= 1'b0; wireClkOut_reg <= 1'b0;
      end else begin
         misoOe_reg <= !sel;
         misoOut_reg <= (asleep || spiCnt_reg == 5'h00) ? regReady : shOut_reg[7];
         wireClkOut_reg <= wireClk_reg & wire_mode;
         wireOe_reg <= wire_mode && rxActive;
         wireOut_reg <= wirePipe_reg[radio_pkg::WIRE_LAT_BITS - 1];
      end
   end
   assign link.miso = misoOut_reg;
   assign link.misoOe = misoOe_reg;
   assign link.wireClk = wireClkOut_reg;
   assign link.wireDataOut = wireOut_reg;
   assign link.wireDataOe = wireOe_reg;
endmodule : radio_power_mode_sequencer

// file: testbench/radio_link_assertions.sv
`timescale 1ns/1ns
// =====================================================
// spi wire checks between controller and radio
module radio_link_assertions (
   input wire logic clock,
   input wire logic nrst,
   input wire logic sck,
   input wire logic sel,
   input wire logic mosi,
   input wire logic misoOe
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   logic [5:0] edgeCnt_reg;
   // sck rises in the open frame; a wake frame has none, so zero is legal too
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         edgeCnt_reg <= 6'h00;
      end else if (sel) begin
         edgeCnt_reg <= 6'h00;
      end else if ($rose(sck)) begin
         edgeCnt_reg <= edgeCnt_reg + 6'h01;
      end
   end
   a_sck_in_frame: assert property (sck |-> !sel)
      else $error("clock outside frame");
   a_select_fall_clean: assert property ($fell(sel) |-> !sck)
      else $error("select fell with clock high");
   a_reset_idle: assert property ($rose(nrst) |-> sel && !sck)
      else $error("link not idle after reset");
   a_mosi_held_high: assert property (sck && $past(sck) |-> $stable(mosi))
      else $error("mosi moved while clock high");
   a_mosi_setup: assert property ($rose(sck) |-> $stable(mosi))
      else $error("mosi moved at clock rise");
   a_frame_bits: assert property ($rose(sel) |-> edgeCnt_reg == 6'h10 || edgeCnt_reg == 6'h00)
      else $error("frame is not sixteen bits");
   a_miso_release: assert property ($rose(sel) |-> ##[0:4] !misoOe)
      else $error("miso still driven after frame");
   a_miso_drive_select: assert property ($rose(misoOe) |-> !sel)
      else $error("miso driven while unselected");
endmodule : radio_link_assertions

// file: testbench/radio_power_mode_sequencer_tb.sv
`timescale 1ns/1ns
// =====================================================
// bench: ahb master, host controller, spi link, radio
module radio_power_mode_sequencer_tb;
   localparam int UNIT = 10;
   localparam int SLACK = 200; // frame time, sync stages and polling
   localparam int BITC = 8 * UNIT; // bit period once rate is 8
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic brownout = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic [3:0] powerState;
   logic regReady;
   int badCount = 0;
   int nChecks = 0;
   int cyc = 0;
   radio_if link();
   radio_power_mode_sequencer #(.RATE_DIV_UNIT(UNIT)) radio_power_mode_sequencer_inst (.clock(clock), .nrst(nrst),
      .brownout(brownout), .link(link.dev), .powerState(powerState), .regReady(regReady));
   radio_host_ctrl radio_host_ctrl_inst (.clock(clock), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .link(link.host));
   radio_link_assertions radio_link_assertions_inst (.clock(clock), .nrst(nrst), .sck(link.sck), .sel(link.sel),
      .mosi(link.mosi), .misoOe(link.misoOe));
   // =====================================================
   // clock, cycle count and watchdog
   always #50 clock = ~clock;
   always @(posedge clock) cyc <= cyc + 1;
   initial begin
      repeat (60000) @(posedge clock);
      badCount++;
      $display("wrong value at %0t: run timed out", $time);
      completeRun();
   end
   // =====================================================
   // shared tasks
   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
      nChecks++;
      if (got !== exp) begin
         badCount++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask : check
   task automatic completeRun();
      $display("checks %0d mismatches %0d", nChecks, badCount);
      if (badCount == 0 && nChecks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : completeRun
   // one word: address phase held until hready, then data phase
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clock);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h000000, a};
      do @(posedge clock); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clock); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask : ahb
   // post a command and poll busy; the read-back word rides along every time
   task automatic cmd(input logic [1:0] op, input logic [6:0] a, input logic [7:0] d, output logic [7:0] q);
      logic [31:0] r;
      ahb(1'b1, radio_pkg::AHB_CMD, {14'h0000, op, 1'b0, a, d}, r);
      r = 32'h1;
      while (r[0] !== 1'b0) ahb(1'b0, radio_pkg::AHB_STATUS, 32'h0, r);
      ahb(1'b0, radio_pkg::AHB_RDATA, 32'h0, r);
      q = r[7:0];
   endtask : cmd
   // time is counted from the command, so the frame itself sits in the slack
   task automatic goState(input logic [3:0] code, input int lat, input string msg);
      int t0;
      logic [7:0] q;
      t0 = cyc;
      cmd(radio_pkg::CMD_WRITE, radio_pkg::REG_POWER, {4'h0, code}, q);
      while (powerState !== code) @(posedge clock);
      if (lat > 0) check({7'h0, cyc - t0 >= lat && cyc - t0 <= lat + SLACK}, 8'h01, msg);
   endtask : goState
   // =====================================================
   // scenarios
   task automatic wakeUp();
      int t0;
      logic [7:0] q;
      logic [31:0] r;
      check({4'h0, powerState}, {4'h0, radio_pkg::PS_DEEPSLEEP}, "not asleep");
      t0 = cyc;
      cmd(radio_pkg::CMD_WAKE, 7'h00, 8'h00, q);
      check({7'h0, cyc - t0 >= radio_pkg::WAKE_CYC}, 8'h01, "wake ended early");
      ahb(1'b0, radio_pkg::AHB_STATUS, 32'h0, r);
      check({7'h0, r[2]}, 8'h01, "miso not high after wake");
      cmd(radio_pkg::CMD_READ, radio_pkg::REG_RATE, 8'h00, q);
      check(q, radio_pkg::RATE_RESET, "rate not at default");
      check({4'h0, powerState}, {4'h0, radio_pkg::PS_POWERDOWN}, "not in power-down");
   endtask : wakeUp
   task automatic testSupply();
      logic [7:0] q;
      brownout <= 1'b1;
      cmd(radio_pkg::CMD_READ, radio_pkg::REG_SUPPLY, 8'h00, q);
      check({7'h0, q[radio_pkg::SUP_BROWNOUT]}, 8'h01, "brown-out flag low");
      brownout <= 1'b0;
      cmd(radio_pkg::CMD_READ, radio_pkg::REG_SUPPLY, 8'h00, q);
      check({7'h0, q[radio_pkg::SUP_BROWNOUT]}, 8'h00, "brown-out flag stuck");
   endtask : testSupply
   task automatic testStates();
      int t0;
      logic [7:0] q;
      goState(radio_pkg::PS_STANDBY, 0, "");
      cmd(radio_pkg::CMD_WRITE, radio_pkg::REG_RATE, 8'h08, q);
      goState(radio_pkg::PS_FULL_TRANSMIT_STATE, radio_pkg::TXON_CYC + BITC, "standby to transmit");
      check({7'h0, regReady}, 8'h01, "supplies not ready");
      cmd(radio_pkg::CMD_READ, radio_pkg::REG_SUPPLY, 8'h00, q);
      check({7'h0, q[radio_pkg::SUP_REGREADY]}, 8'h01, "ready flag low");
      goState(radio_pkg::PS_FULL_RECEIVE_STATE, radio_pkg::TXRX_CYC, "transmit to receive");
      goState(radio_pkg::PS_FULL_TRANSMIT_STATE, radio_pkg::RXTX_CYC, "receive to transmit");
      goState(radio_pkg::PS_STANDBY, 0, "");
      t0 = cyc;
      goState(radio_pkg::PS_FULL_RECEIVE_STATE, radio_pkg::RXON_CYC, "standby to receive");
      cmd(radio_pkg::CMD_READ, radio_pkg::REG_STATE, 8'h00, q);
      check({2'h0, q[5:0]}, {4'h0, radio_pkg::PS_FULL_RECEIVE_STATE}, "receive flags early");
      while (cyc - t0 < radio_pkg::RSSI_CYC + 3 * BITC + SLACK) @(posedge clock);
      cmd(radio_pkg::CMD_READ, radio_pkg::REG_STATE, 8'h00, q);
      check({2'h0, q[5:0]}, {4'h3, radio_pkg::PS_FULL_RECEIVE_STATE}, "receive flags late");
   endtask : testStates
   task automatic testHop();
      int t0;
      logic [7:0] q;
      t0 = cyc;
      cmd(radio_pkg::CMD_WRITE, radio_pkg::REG_CARRIER, 8'h01, q);
      cmd(radio_pkg::CMD_READ, radio_pkg::REG_STATE, 8'h00, q);
      check({7'h0, q[radio_pkg::ST_BUSY]}, 8'h01, "hop not settling");
      while (cyc - t0 < radio_pkg::HOP_CYC + SLACK) @(posedge clock);
      cmd(radio_pkg::CMD_READ, radio_pkg::REG_STATE, 8'h00, q);
      check({7'h0, q[radio_pkg::ST_BUSY]}, 8'h00, "hop too long");
      cmd(radio_pkg::CMD_WRITE, radio_pkg::REG_MODE, 8'h01, q);
      repeat (7 * BITC) @(posedge clock);
      check({6'h0, link.wireDataOe, link.wireDataOut}, 8'h03, "wire pins idle");
   endtask : testHop
   // set then clear the reset bit; the rate written earlier must be gone
   task automatic testReset();
      logic [7:0] q;
      cmd(radio_pkg::CMD_WRITE, radio_pkg::REG_POWER, 8'h85, q);
      cmd(radio_pkg::CMD_WRITE, radio_pkg::REG_POWER, 8'h05, q);
      cmd(radio_pkg::CMD_READ, radio_pkg::REG_RATE, 8'h00, q);
      check(q, radio_pkg::RATE_RESET, "rate survived reset");
   endtask : testReset
   task automatic testSleep();
      logic [7:0] q;
      logic [31:0] r;
      cmd(radio_pkg::CMD_WRITE, radio_pkg::REG_RATE, 8'h08, q);
      goState(radio_pkg::PS_DEEPSLEEP, 0, "");
      wakeUp();
      ahb(1'b0, 8'h0C, 32'h0, r);
      check({7'h0, hresp}, 8'h00, "unmapped read not okay");
   endtask : testSleep
   // =====================================================
   // main sequence
   initial begin
      repeat (6) @(posedge clock);
      nrst <= 1'b1;
      wakeUp();
      testSupply();
      testStates();
      testHop();
      testReset();
      testSleep();
      completeRun();
   end
endmodule : radio_power_mode_sequencer_tb
